//--- ucp_pkg.sv
// constants, carriers and state types of the command port
package ucp_pkg;
  // command codes
  localparam logic [7:0] CMD_SEL_EP_LO = 8'h00;
  localparam logic [7:0] CMD_SEL_EP_HI = 8'h05;
  localparam logic [7:0] CMD_SEL_CLR_LO = 8'h40;
  localparam logic [7:0] CMD_SEL_CLR_HI = 8'h45;
  localparam logic [7:0] CMD_SET_ADDR = 8'hD0;
  localparam logic [7:0] CMD_EP_ENABLE = 8'hD8;
  localparam logic [7:0] CMD_SET_MODE = 8'hF3;
  localparam logic [7:0] CMD_READ_INT = 8'hF4;
  localparam logic [7:0] CMD_FRAME = 8'hF5;
  localparam logic [7:0] CMD_CHIP_ID = 8'hFD;
  localparam logic [7:0] CMD_DEV_STAT = 8'hFE;
  localparam logic [7:0] CMD_ERR_CODE = 8'hFF;
  // field positions, endpoint count
  localparam int ADDR_EN_BIT = 7;
  localparam int INT_DEV_BIT = 7;
  localparam int STAT_SUSP_BIT = 2;
  localparam int STAT_SCHG_BIT = 3;
  localparam int STAT_BRST_BIT = 4;
  localparam int ERR_FLAG_BIT = 4;
  localparam int NUM_EP = 6;
  // values after reset, error codes
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [6:0] BUS_RESET_ADDR = 7'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PID = 4'h1;
  localparam logic [3:0] ERR_DATA_CRC = 4'h5;
  localparam logic [3:0] ERR_TOGGLE = 4'hF;
  // idle time before suspend
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUSPEND_TIME_MS = 3;
  localparam int SUSPEND_CYCLES = SUSPEND_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // microcontroller access
  typedef struct packed {
    logic sel;
    logic cmd;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ucp_mp_req_s;
  // start-of-frame report from the serial engine
  typedef struct packed {
    logic valid;
    logic [10:0] frame;
  } ucp_sof_s;
  typedef enum logic {PH_IDLE, PH_CMD} ucp_phase_e;
endpackage

//--- ucp_sticky_flag.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/1ns
module ucp_sticky_flag #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  // hold, clear on request, set always wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= '0;
    end else if (ce_i) begin
      q_o <= (q_o & ~clr_i) | set_i;
    end
  end
endmodule

//--- ucp_idle_timer.sv
// bus idle timer, raises idle after the limit passes
`timescale 1ns/1ns
module ucp_idle_timer #(
  parameter int LIMIT = 300000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic activity_i,
  output logic idle_o
);
  localparam int CW = $clog2(LIMIT + 1) + 1;
  logic [CW-1:0] cnt;
  wire expired = (cnt == CW'(LIMIT));
  // count quiet cycles, any activity restarts
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      idle_o <= 1'b0;
    end else if (ce_i) begin
      if (activity_i) begin
        cnt <= '0;
        idle_o <= 1'b0;
      end else if (!expired) begin
        cnt <= cnt + 1'b1;
      end else begin
        idle_o <= 1'b1;
      end
    end
  end
endmodule

//--- ucp_command_port.sv
// command interpreter between microcontroller and usb interface engine
//
// How it works
// - each operation is a command byte access, then data byte accesses.
// - command D0 write loads the function address and enable.
// - a failed status phase drops the pending address; old one stays.
// - address byte bits 6..0 address, bit 7 enable; zero at power-up.
// - bus reset forces address zero and sets enable.
// - command D8 write bit 0 enables or disables non-control endpoints.
// - command F3 write bit 0 makes NAKs raise endpoint interrupts.
// - command F4 read returns the interrupt origin byte.
// - commands 40..45 select endpoint; read clears its interrupt, write sets status.
// - command F5 returns the 11-bit frame number, low byte first.
// - without a new start-of-frame the last frame number is kept.
// - a start-of-frame with CRC error still stores its number.
// - command FD returns the 16-bit chip code, low byte first.
// - command FE read returns device status; write with suspend bit 0 while suspended pulses wake-up.
// - command FF returns error code and occurred flag; transfer clears flag.
// - commands 00..05 select endpoint; optional read returns buffer info.
// - suspend after 3 ms quiet; change and bus reset flags clear on read.
// - interrupt byte bit 7 flags device event; status read clears it.
// - error codes 0 none, 1 PID, 5 data CRC, F wrong toggle.
`timescale 1ns/1ns
module ucp_command_port #(
  parameter int SUSPEND_CYCLES = ucp_pkg::SUSPEND_CYCLES,
  parameter logic [15:0] CHIP_ID = 16'h5A5A // arbitrary value
) (
  // clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // microcontroller access
  input wire ucp_pkg::ucp_mp_req_s MP_REQ_I,
  output logic [7:0] MP_RDATA_O,
  output logic INT_N_O,
  // serial engine events
  input wire ucp_pkg::ucp_sof_s SOF_I,
  input wire logic BUS_RESET_I,
  input wire logic ACTIVITY_I,
  input wire logic ADDR_OK_I,
  input wire logic ADDR_FAIL_I,
  input wire logic [5:0] EP_DONE_I,
  input wire logic [5:0] EP_NAK_I,
  input wire logic ERR_EV_I,
  input wire logic [3:0] ERR_CODE_I,
  input wire logic XFER_START_I,
  input wire logic [7:0] EP_INFO_I,
  // device settings to the engine
  output logic [6:0] FUNC_ADDR_O,
  output logic FUNC_EN_O,
  output logic EP_ENABLE_O,
  output logic NAK_MODE_O,
  output logic [2:0] EP_SEL_O,
  output logic [7:0] EP_STAT_O,
  output logic EP_STAT_WE_O,
  output logic SUSPEND_O,
  output logic WAKEUP_O
);
  ucp_pkg::ucp_phase_e phase, next_phase;
  logic [7:0] cmd_code;
  logic byte_idx;
  logic addr_pend;
  logic [7:0] pend_val;
  logic [10:0] frame;
  logic [3:0] err_code;
  logic susp_d;
  logic [5:0] ep_int;
  logic [2:0] dev_flags;
  logic err_flag;
  logic susp;

  // access decode
  wire cmd_wr = MP_REQ_I.sel & MP_REQ_I.wr & MP_REQ_I.cmd;
  wire data_wr = MP_REQ_I.sel & MP_REQ_I.wr & ~MP_REQ_I.cmd & (phase == ucp_pkg::PH_CMD);
  wire data_rd = MP_REQ_I.sel & MP_REQ_I.rd & ~MP_REQ_I.cmd & (phase == ucp_pkg::PH_CMD);
  wire [7:0] wd = MP_REQ_I.wdata;
  wire new_sel = (wd <= ucp_pkg::CMD_SEL_EP_HI); // select range starts at code zero
  wire new_selclr = (wd >= ucp_pkg::CMD_SEL_CLR_LO) && (wd <= ucp_pkg::CMD_SEL_CLR_HI);
  wire is_sel = (cmd_code <= ucp_pkg::CMD_SEL_EP_HI); // select range starts at code zero
  wire is_selclr = (cmd_code >= ucp_pkg::CMD_SEL_CLR_LO) &&
                   (cmd_code <= ucp_pkg::CMD_SEL_CLR_HI);
  wire wr_addr = data_wr && (cmd_code == ucp_pkg::CMD_SET_ADDR);
  wire wr_epen = data_wr && (cmd_code == ucp_pkg::CMD_EP_ENABLE);
  wire wr_mode = data_wr && (cmd_code == ucp_pkg::CMD_SET_MODE);
  wire wr_stat = data_wr && (cmd_code == ucp_pkg::CMD_DEV_STAT);
  wire rd_stat = data_rd && (cmd_code == ucp_pkg::CMD_DEV_STAT);

  // command phase tracking
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ucp_pkg::PH_IDLE: begin
        if (cmd_wr) next_phase = ucp_pkg::PH_CMD;
      end
      ucp_pkg::PH_CMD: begin
        next_phase = ucp_pkg::PH_CMD;
      end
    endcase
  end

  // command byte, byte index and endpoint selection
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      phase <= ucp_pkg::PH_IDLE;
      cmd_code <= 8'h00;
      byte_idx <= 1'b0;
      EP_SEL_O <= 3'h0;
    end else if (CE_I) begin
      phase <= next_phase;
      if (cmd_wr) begin
        cmd_code <= wd;
        byte_idx <= 1'b0;
        if (new_sel || new_selclr) EP_SEL_O <= wd[2:0];
      end else if (data_rd) begin
        byte_idx <= ~byte_idx;
      end
    end
  end

  // function address with commit on status phase outcome
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      FUNC_ADDR_O <= ucp_pkg::ADDR_RST[6:0];
      FUNC_EN_O <= ucp_pkg::ADDR_RST[ucp_pkg::ADDR_EN_BIT];
      addr_pend <= 1'b0;
      pend_val <= ucp_pkg::ADDR_RST;
    end else if (CE_I) begin
      if (BUS_RESET_I) begin
        FUNC_ADDR_O <= ucp_pkg::BUS_RESET_ADDR;
        FUNC_EN_O <= 1'b1;
        addr_pend <= 1'b0;
      end else if (wr_addr) begin
        pend_val <= wd;
        addr_pend <= 1'b1;
      end else if (addr_pend && ADDR_OK_I) begin
        FUNC_ADDR_O <= pend_val[6:0];
        FUNC_EN_O <= pend_val[ucp_pkg::ADDR_EN_BIT];
        addr_pend <= 1'b0;
      end else if (ADDR_FAIL_I) begin
        addr_pend <= 1'b0;
      end
    end
  end

  // mode, endpoint enable, endpoint status strobe, wake-up
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      EP_ENABLE_O <= 1'b0;
      NAK_MODE_O <= 1'b0;
      EP_STAT_O <= 8'h00;
      EP_STAT_WE_O <= 1'b0;
      WAKEUP_O <= 1'b0;
    end else if (CE_I) begin
      if (wr_epen) EP_ENABLE_O <= wd[0];
      if (wr_mode) NAK_MODE_O <= wd[0];
      EP_STAT_WE_O <= data_wr && is_selclr;
      if (data_wr && is_selclr) EP_STAT_O <= wd;
      WAKEUP_O <= wr_stat && susp && !wd[ucp_pkg::STAT_SUSP_BIT];
    end
  end

  // frame number and error code capture
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      frame <= ucp_pkg::FRAME_RST;
      err_code <= ucp_pkg::ERR_NONE;
      susp_d <= 1'b0;
    end else if (CE_I) begin
      if (SOF_I.valid) frame <= SOF_I.frame;
      if (ERR_EV_I) err_code <= ERR_CODE_I;
      susp_d <= susp;
    end
  end

  // endpoint interrupts, control endpoints always pass
  wire [5:0] ep_gate = {{4{EP_ENABLE_O}}, 2'b11};
  wire [5:0] ep_set = (EP_DONE_I | (EP_NAK_I & {6{NAK_MODE_O}})) & ep_gate;
  wire [5:0] ep_clr = (data_rd && is_selclr) ? 6'(6'd1 << cmd_code[2:0]) : 6'h00;
  ucp_sticky_flag #(
    .W(ucp_pkg::NUM_EP)
  ) u_ep_int (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .set_i(ep_set),
    .clr_i(ep_clr),
    .q_o(ep_int)
  );

  // device flags: {device event, bus reset, suspend change}
  wire susp_tog = susp ^ susp_d;
  wire [2:0] dev_set = {BUS_RESET_I | susp_tog, BUS_RESET_I, susp_tog};
  wire [2:0] dev_clr = {3{rd_stat}};
  ucp_sticky_flag #(
    .W(3)
  ) u_dev_flags (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .set_i(dev_set),
    .clr_i(dev_clr),
    .q_o(dev_flags)
  );

  // error occurred flag, a new transfer clears it
  ucp_sticky_flag #(
    .W(1)
  ) u_err_flag (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .set_i(ERR_EV_I),
    .clr_i(XFER_START_I),
    .q_o(err_flag)
  );

  // suspend detection on quiet upstream port
  ucp_idle_timer #(
    .LIMIT(SUSPEND_CYCLES)
  ) u_idle (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .activity_i(ACTIVITY_I | BUS_RESET_I),
    .idle_o(susp)
  );
  assign SUSPEND_O = susp;

  // read bytes
  wire [7:0] int_byte = {dev_flags[2], 1'b0, ep_int};
  wire [7:0] stat_byte = {3'b000, dev_flags[1], dev_flags[0], susp, 2'b00};
  wire [7:0] err_byte = {3'b000, err_flag, err_code};
  wire [7:0] frame_byte = byte_idx ? {5'b00000, frame[10:8]} : frame[7:0];
  wire [7:0] chip_byte = byte_idx ? CHIP_ID[15:8] : CHIP_ID[7:0];
  wire [7:0] rd_mux =
    (cmd_code == ucp_pkg::CMD_READ_INT) ? int_byte :
    (cmd_code == ucp_pkg::CMD_FRAME) ? frame_byte :
    (cmd_code == ucp_pkg::CMD_CHIP_ID) ? chip_byte :
    (cmd_code == ucp_pkg::CMD_DEV_STAT) ? stat_byte :
    (cmd_code == ucp_pkg::CMD_ERR_CODE) ? err_byte :
    (is_sel || is_selclr) ? EP_INFO_I : 8'h00;
  assign INT_N_O = ~|int_byte;

  // read data register
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MP_RDATA_O <= 8'h00;
    end else if (CE_I && data_rd) begin
      MP_RDATA_O <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);

  addr_commit_a: assert property (
    CE_I && addr_pend && ADDR_OK_I && !BUS_RESET_I && !wr_addr
    |=> FUNC_ADDR_O == $past(pend_val[6:0]) && FUNC_EN_O == $past(pend_val[7]))
    else $error("address not committed");
  addr_keep_a: assert property (
    CE_I && ADDR_FAIL_I && !ADDR_OK_I && !BUS_RESET_I |=> $stable(FUNC_ADDR_O))
    else $error("address changed on failed status");
  bus_reset_a: assert property (
    CE_I && BUS_RESET_I |=> FUNC_ADDR_O == 7'h00 && FUNC_EN_O && int_byte[7])
    else $error("bus reset not applied");
  ep_enable_a: assert property (
    CE_I && wr_epen |=> EP_ENABLE_O == $past(wd[0]))
    else $error("endpoint enable not stored");
  nak_quiet_a: assert property (
    CE_I && !NAK_MODE_O |=> (ep_int & ~$past(ep_int) & ~$past(EP_DONE_I)) == 6'h00)
    else $error("nak raised interrupt in quiet mode");
  int_read_a: assert property (
    CE_I && data_rd && cmd_code == ucp_pkg::CMD_READ_INT |=> MP_RDATA_O == $past(int_byte))
    else $error("interrupt byte wrong");
  sel_clear_a: assert property (
    CE_I && data_rd && is_selclr |=> (ep_int & $past(ep_clr)) == ($past(ep_set) & $past(ep_clr)))
    else $error("endpoint interrupt not cleared");

  sequence frame_lo_s;
    CE_I && data_rd && cmd_code == ucp_pkg::CMD_FRAME && !byte_idx;
  endsequence
  sequence frame_hi_s;
    CE_I && data_rd && cmd_code == ucp_pkg::CMD_FRAME && byte_idx;
  endsequence
  frame_lo_a: assert property (
    frame_lo_s |=> MP_RDATA_O == $past(frame[7:0]))
    else $error("frame low byte wrong");
  frame_bytes_a: assert property (
    frame_hi_s |=> MP_RDATA_O == {5'b00000, $past(frame[10:8])})
    else $error("frame high byte wrong");
  frame_store_a: assert property (
    CE_I && SOF_I.valid |=> frame == $past(SOF_I.frame))
    else $error("frame number not stored");
  chip_hi_a: assert property (
    CE_I && data_rd && cmd_code == ucp_pkg::CMD_CHIP_ID && byte_idx
    |=> MP_RDATA_O == CHIP_ID[15:8])
    else $error("chip code high byte wrong");
  err_catch_a: assert property (
    CE_I && ERR_EV_I |=> err_flag && err_code == $past(ERR_CODE_I))
    else $error("error not captured");
  susp_change_a: assert property (
    CE_I && susp_tog |=> dev_flags[0] && dev_flags[2])
    else $error("suspend change not flagged");

  // address, selection, strobe and freeze checks
  addr_drop_a: assert property (
    CE_I && ADDR_FAIL_I && !wr_addr |=> !addr_pend)
    else $error("pending address kept after failed status");
  sel_update_a: assert property (
    CE_I && cmd_wr && (new_sel || new_selclr) |=> EP_SEL_O == $past(wd[2:0]))
    else $error("endpoint selection not taken");
  wakeup_pulse_a: assert property (
    CE_I && wr_stat |=> WAKEUP_O == ($past(susp) && !$past(wd[ucp_pkg::STAT_SUSP_BIT])))
    else $error("wake-up pulse wrong");
  ce_freeze_a: assert property (
    !CE_I |=> $stable(FUNC_ADDR_O) && $stable(EP_ENABLE_O) && $stable(MP_RDATA_O))
    else $error("state moved while clock enable low");

  // read-back and flag clear checks
  byte_restart_a: assert property (
    CE_I && cmd_wr |=> !byte_idx)
    else $error("byte index not restarted");
  chip_lo_a: assert property (
    CE_I && data_rd && cmd_code == ucp_pkg::CMD_CHIP_ID && !byte_idx
    |=> MP_RDATA_O == CHIP_ID[7:0])
    else $error("chip code low byte wrong");
  rdata_hold_a: assert property (
    !(CE_I && data_rd) |=> $stable(MP_RDATA_O))
    else $error("read byte changed without a read");
  stat_clear_a: assert property (
    CE_I && rd_stat && !BUS_RESET_I && !susp_tog |=> dev_flags == 3'b000)
    else $error("status flags not cleared on read");
  err_clear_a: assert property (
    CE_I && XFER_START_I && !ERR_EV_I |=> !err_flag)
    else $error("error flag not cleared");

  // endpoint interrupt gating checks
  ep_gate_a: assert property (
    CE_I && !EP_ENABLE_O |=> (ep_int & ~$past(ep_int) & 6'h3C) == 6'h00)
    else $error("disabled endpoint raised interrupt");
  nak_report_a: assert property (
    CE_I && NAK_MODE_O |=> ($past(EP_NAK_I) & $past(ep_gate) & ~ep_int) == 6'h00)
    else $error("nak not reported");
endmodule

//--- ucp_mcu_model.sv
// microcontroller model issuing command and data accesses
`timescale 1ns/1ns
module ucp_mcu_model (
  // clock
  input wire logic clk_i,
  // command port
  output ucp_pkg::ucp_mp_req_s mp_req_o,
  input wire logic [7:0] rdata_i
);
  logic [7:0] last_data;
  // idle bus at time zero
  initial begin
    mp_req_o = '0;
    last_data = 8'h00;
  end
  // one-cycle strobe, then one idle cycle; released byte lines show the inverse of the last value
  task automatic access(input logic cmd, input logic wr, input logic [7:0] data,
      output logic [7:0] rdata);
    @(negedge clk_i);
    mp_req_o = '{sel: 1'h1, cmd: cmd, wr: wr, rd: ~wr, wdata: data};
    last_data = data;
    @(negedge clk_i);
    mp_req_o = '{sel: 1'h0, cmd: 1'h0, wr: 1'h0, rd: 1'h0, wdata: ~last_data};
    rdata = rdata_i; // read byte stands from the cycle after the strobe
  endtask
  // command byte always comes first, data bytes after it
  task automatic command(input logic [7:0] code);
    logic [7:0] unused;
    access(1'h1, 1'h1, code, unused);
  endtask
  // data byte write
  task automatic write_data(input logic [7:0] data);
    logic [7:0] unused;
    access(1'h0, 1'h1, data, unused);
  endtask
  // data byte read
  task automatic read_data(output logic [7:0] data);
    access(1'h0, 1'h0, ~last_data, data);
  endtask
endmodule

//--- test_ucp_command_port.sv
// self-checking bench for the usb device command port
`timescale 1ns/1ns
module test_ucp_command_port;
  // pulse masks on the event vector
  localparam logic [17:0] ev_brst = 18'h0_0001;
  localparam logic [17:0] ev_ok = 18'h0_0002;
  localparam logic [17:0] ev_fail = 18'h0_0004;
  localparam logic [17:0] ev_err = 18'h0_0008;
  localparam logic [17:0] ev_xfer = 18'h0_0010;
  localparam logic [17:0] ev_sof = 18'h0_0020;
  localparam logic [7:0] c_int = ucp_pkg::CMD_READ_INT;
  localparam logic [7:0] c_stat = ucp_pkg::CMD_DEV_STAT;
  localparam logic [7:0] c_frame = ucp_pkg::CMD_FRAME;
  localparam logic [7:0] c_err = ucp_pkg::CMD_ERR_CODE;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic activity = 1'h1;
  logic ce = 1'h1;
  logic [17:0] ev = '0;
  logic [3:0] err_code = 4'h0;
  logic [10:0] frame = 11'h000;
  logic [7:0] ep_info = 8'h00;
  ucp_pkg::ucp_mp_req_s mp_req;
  ucp_pkg::ucp_sof_s sof;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [6:0] func_addr;
  logic [2:0] ep_sel;
  logic [7:0] ep_stat;
  logic func_en, ep_en, nak_mode, stat_we, susp, wakeup, int_n;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // clock and start-of-frame carrier
  always #5 clk_sys = ~clk_sys;
  assign sof = '{valid: ev[5], frame: frame};
  // device under test, short suspend count; chip code value is arbitrary
  ucp_command_port #(.SUSPEND_CYCLES(20), .CHIP_ID(16'h1234)) ucp_command_port_inst (
    .CLK_SYS_I(clk_sys), .RSTN_I(rstn), .CE_I(ce), .MP_REQ_I(mp_req),
    .MP_RDATA_O(rdata), .INT_N_O(int_n), .SOF_I(sof), .BUS_RESET_I(ev[0]),
    .ACTIVITY_I(activity), .ADDR_OK_I(ev[1]), .ADDR_FAIL_I(ev[2]),
    .EP_DONE_I(ev[11:6]), .EP_NAK_I(ev[17:12]), .ERR_EV_I(ev[3]),
    .ERR_CODE_I(err_code), .XFER_START_I(ev[4]), .EP_INFO_I(ep_info),
    .FUNC_ADDR_O(func_addr), .FUNC_EN_O(func_en), .EP_ENABLE_O(ep_en),
    .NAK_MODE_O(nak_mode), .EP_SEL_O(ep_sel), .EP_STAT_O(ep_stat),
    .EP_STAT_WE_O(stat_we), .SUSPEND_O(susp), .WAKEUP_O(wakeup));
  // microcontroller side
  ucp_mcu_model ucp_mcu_model_inst (.clk_i(clk_sys), .mp_req_o(mp_req), .rdata_i(rdata));
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one-cycle event pulse; its effect shows at the following falling edge
  task automatic pulse(input logic [17:0] p);
    @(negedge clk_sys);
    ev = p;
    @(negedge clk_sys);
    ev = '0;
  endtask
  task automatic rd_next(input logic [7:0] exp);
    ucp_mcu_model_inst.read_data(d);
    chk_byte(d, exp, "read");
  endtask
  task automatic rd_cmd(input logic [7:0] code, input logic [7:0] exp);
    ucp_mcu_model_inst.command(code);
    rd_next(exp);
  endtask
  task automatic wr_cmd(input logic [7:0] code, input logic [7:0] data);
    ucp_mcu_model_inst.command(code);
    ucp_mcu_model_inst.write_data(data);
  endtask
  task automatic t_reset();
    chk_flag(int_n, 1'h1, "int");
    chk_byte({func_en, func_addr}, ucp_pkg::ADDR_RST, "addr");
    chk_flag(ep_en, 1'h0, "ep enable");
    chk_flag(nak_mode, 1'h0, "nak mode");
    $display("test reset done");
  endtask
  task automatic t_address();
    wr_cmd(ucp_pkg::CMD_SET_ADDR, 8'h85);
    pulse(ev_ok);
    chk_byte({func_en, func_addr}, 8'h85, "addr");
    wr_cmd(ucp_pkg::CMD_SET_ADDR, 8'h33);
    pulse(ev_fail);
    chk_byte({func_en, func_addr}, 8'h85, "addr kept");
    pulse(ev_brst);
    chk_byte({func_en, func_addr}, 8'h80, "bus reset addr");
    chk_flag(int_n, 1'h0, "int");
    rd_cmd(c_int, 8'h80);
    rd_cmd(c_stat, 8'h10);
    rd_cmd(c_stat, 8'h00);
    chk_flag(int_n, 1'h1, "int");
    $display("test address done");
  endtask
  task automatic t_ints();
    pulse(18'h0_0040);
    rd_cmd(c_int, 8'h01);
    rd_cmd(8'h40, ep_info);
    rd_cmd(c_int, 8'h00);
    pulse(18'h0_0100);
    rd_cmd(c_int, 8'h00);
    wr_cmd(ucp_pkg::CMD_EP_ENABLE, 8'h01);
    chk_flag(ep_en, 1'h1, "ep enable");
    pulse(18'h0_0100);
    rd_cmd(c_int, 8'h04);
    pulse(18'h0_2000);
    rd_cmd(c_int, 8'h04);
    wr_cmd(ucp_pkg::CMD_SET_MODE, 8'h01);
    chk_flag(nak_mode, 1'h1, "nak mode");
    pulse(18'h0_2000);
    rd_cmd(c_int, 8'h06);
    rd_cmd(8'h42, ep_info);
    rd_cmd(8'h41, ep_info);
    rd_cmd(c_int, 8'h00);
    wr_cmd(8'h43, 8'hA5);
    chk_byte(ep_stat, 8'hA5, "ep status");
    chk_byte({5'h00, ep_sel}, 8'h03, "ep sel");
    chk_flag(stat_we, 1'h1, "status strobe");
    wait_cy(1);
    chk_flag(stat_we, 1'h0, "status strobe");
    ce = 1'h0;
    wr_cmd(ucp_pkg::CMD_EP_ENABLE, 8'h00);
    chk_flag(ep_en, 1'h1, "frozen enable");
    ce = 1'h1;
    $display("test interrupts done");
  endtask
  task automatic t_frame_id();
    frame = 11'h5A3;
    pulse(ev_sof);
    frame = 11'h2FF;
    rd_cmd(c_frame, 8'hA3);
    rd_next(8'h05);
    rd_next(8'hA3);
    rd_cmd(c_frame, 8'hA3);
    frame = 11'h7FF;
    pulse(ev_sof);
    rd_cmd(c_frame, 8'hFF);
    rd_next(8'h07);
    rd_cmd(ucp_pkg::CMD_CHIP_ID, 8'h34);
    rd_next(8'h12);
    $display("test frame and id done");
  endtask
  task automatic t_error();
    logic [3:0] codes [4] = '{ucp_pkg::ERR_NONE, ucp_pkg::ERR_PID,
                              ucp_pkg::ERR_DATA_CRC, ucp_pkg::ERR_TOGGLE};
    foreach (codes[i]) begin
      err_code = codes[i];
      pulse(ev_err);
      rd_cmd(c_err, {3'h0, 1'h1, codes[i]});
      pulse(ev_xfer);
      rd_cmd(c_err, {4'h0, codes[i]});
    end
    $display("test error code done");
  endtask
  task automatic t_select();
    for (int i = 0; i < 6; i++) begin
      ep_info = 8'hC0 + 8'(i);
      rd_cmd(8'(i), 8'hC0 + 8'(i));
      chk_byte({5'h00, ep_sel}, 8'(i), "ep sel");
    end
    $display("test select done");
  endtask
  task automatic t_suspend();
    activity = 1'h0;
    wait_cy(15);
    chk_flag(susp, 1'h0, "suspend early");
    wait_cy(10);
    chk_flag(susp, 1'h1, "suspend");
    chk_flag(int_n, 1'h0, "int");
    rd_cmd(c_stat, 8'h0C);
    wr_cmd(c_stat, 8'h00);
    chk_flag(wakeup, 1'h1, "wakeup");
    wait_cy(1);
    chk_flag(wakeup, 1'h0, "wakeup pulse");
    activity = 1'h1;
    wait_cy(3);
    chk_flag(susp, 1'h0, "resume");
    rd_cmd(c_stat, 8'h08);
    chk_flag(int_n, 1'h1, "int");
    wr_cmd(c_stat, 8'h00);
    chk_flag(wakeup, 1'h0, "no wakeup");
    $display("test suspend done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    rstn = 1'h1;
    t_reset();
    t_address();
    t_ints();
    t_frame_id();
    t_error();
    t_select();
    t_suspend();
    final_report();
  end
endmodule
